// file: lcrs_pkg.sv
// Package with register offsets, field layouts and timing constants of the ramp sequencer.
package lcrs_pkg;
  localparam logic [6:0] ADDR_FADE_TIMING = 7'h11;
  localparam logic [6:0] ADDR_RISE_TIMING = 7'h12;
  localparam int FADE_LSB = 0;
  localparam int FADE_MSB = 2;
  localparam int HOLD_LSB = 3;
  localparam int HOLD_MSB = 5;
  localparam logic [7:0] FADE_RD_MASK  = 8'h3F;
  localparam logic [7:0] RISE_RD_MASK  = 8'h07;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [2:0] DAC_FULL      = 3'h7;
  localparam logic [2:0] DAC_ZERO      = 3'h0;
  localparam logic [2:0] CODE_OFF      = 3'h0;
  // PWM timing clock rate in Hz; 1/16 s is this many timing ticks.
  localparam int PWM_HZ          = 32768;
  localparam int SIXTEENTH_TICKS = PWM_HZ / 16;
  localparam int TICK_W          = 18;
  typedef enum logic [2:0] {
    ST_RUN  = 3'b000,
    ST_HOLD = 3'b001,
    ST_FADE = 3'b010,
    ST_OFF  = 3'b011,
    ST_RISE = 3'b100
  } lcrs_state_t;
endpackage

// file: lcrs_sequencer.sv
// Hold-off, fade-off and ramp-up sequencer driving the master current fade DAC.
// How it works
// - Fade code picks 1/16s..4s fade-off time
// - Fade code zero: shutdown right after hold-off
// - Hold code picks zero or 1/16s..4s delay
// - Rise code picks 1/16s..4s ramp-up time
// - Rise code zero: full current at once
// - Durations count 32768 Hz timing clock ticks
// - Timing uses PWM clock, not serial clock
// - Internal oscillator kept running during sequences
// - Sequencer steps a 3-bit master DAC
// - All ports scale by same ratio
// - Global current setting caps DAC level
// - Full current held throughout hold-off
// - Status flags show hold, fade, rise
`timescale 1ns/1ps
`default_nettype none
module lcrs_sequencer (
  // Clock and reset.
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // PWM timing clock tick, one cycle per timing clock period.
  input  wire logic       i_pwm_tick,
  input  wire logic       i_osc_internal,
  // Register port from the serial host interface.
  input  wire logic       i_reg_wr,
  input  wire logic [6:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // Configuration and global current.
  input  wire logic       i_shutdown_req,
  input  wire logic       i_rise_enable,
  input  wire logic [2:0] i_global_iset,
  // Status and analog controls.
  output logic            o_in_hold,
  output logic            o_in_fade,
  output logic            o_in_rise,
  output logic            o_shutdown,
  output logic            o_osc_run,
  output logic      [2:0] o_master_dac
);

  logic [7:0]                fade_timing;
  logic [7:0]                rise_timing;
  lcrs_pkg::lcrs_state_t     state;
  lcrs_pkg::lcrs_state_t     next_state;
  logic [lcrs_pkg::TICK_W-1:0] tick_cnt;
  logic [lcrs_pkg::TICK_W-1:0] step_len;
  logic [2:0]                level;
  logic                      req_q;
  logic                      done;

  // Total ticks of a 3-bit duration code: 1/16 s doubled per code step.
  function automatic logic [lcrs_pkg::TICK_W-1:0] code_ticks(input logic [2:0] code);
    code_ticks = lcrs_pkg::TICK_W'(lcrs_pkg::SIXTEENTH_TICKS) << (code - 3'h1);
  endfunction

  // Registers, with only the documented bits stored.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      fade_timing <= lcrs_pkg::REG_RESET;
      rise_timing <= lcrs_pkg::REG_RESET;
    end
    else if (i_reg_wr && i_reg_addr == lcrs_pkg::ADDR_FADE_TIMING)
      fade_timing <= i_reg_wdata & lcrs_pkg::FADE_RD_MASK;
    else if (i_reg_wr && i_reg_addr == lcrs_pkg::ADDR_RISE_TIMING)
      rise_timing <= i_reg_wdata & lcrs_pkg::RISE_RD_MASK;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_reg_rdata <= lcrs_pkg::REG_RESET;
    else if (i_reg_addr == lcrs_pkg::ADDR_FADE_TIMING)
      o_reg_rdata <= fade_timing;
    else if (i_reg_addr == lcrs_pkg::ADDR_RISE_TIMING)
      o_reg_rdata <= rise_timing;
    else
      o_reg_rdata <= lcrs_pkg::REG_RESET;
  end

  // Duration codes of both timing registers.
  wire logic [2:0] hold_code = fade_timing[lcrs_pkg::HOLD_MSB:lcrs_pkg::HOLD_LSB];
  wire logic [2:0] fade_code = fade_timing[lcrs_pkg::FADE_MSB:lcrs_pkg::FADE_LSB];
  wire logic [2:0] rise_code = rise_timing[lcrs_pkg::FADE_MSB:lcrs_pkg::FADE_LSB];

  // Hold uses the whole duration; fade and rise split it into seven DAC steps.
  always_comb
  begin
    case (state)
      lcrs_pkg::ST_HOLD: step_len = code_ticks(hold_code);
      lcrs_pkg::ST_FADE: step_len = code_ticks(fade_code) / lcrs_pkg::TICK_W'(lcrs_pkg::DAC_FULL);
      lcrs_pkg::ST_RISE: step_len = code_ticks(rise_code) / lcrs_pkg::TICK_W'(lcrs_pkg::DAC_FULL);
      default:           step_len = '0;
    endcase
  end

  assign done = (tick_cnt + 1'b1 >= step_len);

  always_comb
  begin
    next_state = state;
    case (state)
      lcrs_pkg::ST_RUN:
        if (i_shutdown_req && !req_q)
          next_state = (hold_code != lcrs_pkg::CODE_OFF) ? lcrs_pkg::ST_HOLD
                     : (fade_code != lcrs_pkg::CODE_OFF) ? lcrs_pkg::ST_FADE : lcrs_pkg::ST_OFF;
      lcrs_pkg::ST_HOLD:
        if (i_pwm_tick && done)
          next_state = (fade_code != lcrs_pkg::CODE_OFF) ? lcrs_pkg::ST_FADE : lcrs_pkg::ST_OFF;
      lcrs_pkg::ST_FADE:
        if (i_pwm_tick && done && level == lcrs_pkg::DAC_ZERO + 3'h1)
          next_state = lcrs_pkg::ST_OFF;
      lcrs_pkg::ST_OFF:
        if (!i_shutdown_req)
          next_state = (i_rise_enable && rise_code != lcrs_pkg::CODE_OFF)
                     ? lcrs_pkg::ST_RISE : lcrs_pkg::ST_RUN;
      lcrs_pkg::ST_RISE:
        if (i_pwm_tick && done && level == lcrs_pkg::DAC_FULL - 3'h1)
          next_state = lcrs_pkg::ST_RUN;
      default:
        next_state = lcrs_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state <= lcrs_pkg::ST_RUN;
      req_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      req_q <= i_shutdown_req;
    end
  end

  // Tick counter advances only on PWM timing clock ticks.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || next_state != state)
      tick_cnt <= '0;
    else if (i_pwm_tick)
      tick_cnt <= done ? '0 : tick_cnt + 1'b1;
  end

  // Fade level steps one code per step time.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      level <= lcrs_pkg::DAC_FULL;
    else if (next_state == lcrs_pkg::ST_OFF)
      level <= lcrs_pkg::DAC_ZERO;
    else if (next_state == lcrs_pkg::ST_RUN || next_state == lcrs_pkg::ST_HOLD)
      level <= lcrs_pkg::DAC_FULL;
    else if (state == lcrs_pkg::ST_FADE && i_pwm_tick && done)
      level <= level - 3'h1;
    else if (state == lcrs_pkg::ST_RISE && i_pwm_tick && done)
      level <= level + 3'h1;
  end

  // The master reference follows the lower of fade level and global setting.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_master_dac <= lcrs_pkg::DAC_FULL;
    else
      o_master_dac <= (level < i_global_iset) ? level : i_global_iset;
  end

  assign o_in_hold  = (state == lcrs_pkg::ST_HOLD);
  assign o_in_fade  = (state == lcrs_pkg::ST_FADE);
  assign o_in_rise  = (state == lcrs_pkg::ST_RISE);
  assign o_shutdown = (state == lcrs_pkg::ST_OFF);
  assign o_osc_run  = i_osc_internal && (o_in_hold || o_in_fade || o_in_rise);

  // Checks of the sequencing rules, all on the system clock.
  chk_master_cap: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_master_dac <= $past(i_global_iset)) else $error("master dac above global cap");
  chk_hold_full: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_in_hold |=> o_master_dac == $past(i_global_iset)) else $error("current dropped in hold");
  chk_off_zero: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_shutdown && $past(o_shutdown) |-> o_master_dac == lcrs_pkg::DAC_ZERO) else $error("dac not zero in shutdown");
  chk_fade_down: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_in_fade && $past(o_in_fade) |-> level <= $past(level)) else $error("fade level rose");
  chk_rise_up: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_in_rise && $past(o_in_rise) |-> level >= $past(level)) else $error("rise level fell");
  chk_no_fade: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_in_hold && fade_code == 3'h0 && !i_reg_wr ##1 !o_in_hold |-> o_shutdown) else $error("fade with code zero");
  chk_instant_on: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_shutdown && !i_shutdown_req && !(i_rise_enable && rise_code != 3'h0) |=> !o_shutdown && !o_in_rise)
    else $error("ramp-up when disabled");
  chk_osc_run: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_osc_internal && o_in_fade |=> !i_osc_internal || o_osc_run || o_shutdown) else $error("oscillator stopped in fade");
  chk_start_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !o_in_hold && !o_in_fade && !o_in_rise && !o_shutdown && i_shutdown_req && !$past(i_shutdown_req)
    && hold_code != lcrs_pkg::CODE_OFF |=> o_in_hold) else $error("shutdown request did not start hold");
  chk_wake_rise: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_shutdown && !i_shutdown_req && i_rise_enable && rise_code != lcrs_pkg::CODE_OFF |=> o_in_rise)
    else $error("wake did not start ramp-up");
  chk_rdata_zero: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (o_reg_rdata & ~lcrs_pkg::FADE_RD_MASK) == lcrs_pkg::REG_RESET) else $error("read data upper bits set");
  chk_status_excl: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $onehot0({o_in_hold, o_in_fade, o_in_rise, o_shutdown})) else $error("status flags overlap");
  chk_fade_step: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_in_fade && $past(o_in_fade) && level != $past(level) |-> level == $past(level) - 3'h1) else $error("fade skipped a step");
  chk_rise_step: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_in_rise && $past(o_in_rise) && level != $past(level) |-> level == $past(level) + 3'h1) else $error("rise skipped a step");
  chk_rise_cap: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_in_rise |=> o_master_dac <= $past(level)) else $error("dac above ramp level in rise");
  chk_read_zero: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (fade_timing & ~lcrs_pkg::FADE_RD_MASK) == 8'h00 && (rise_timing & ~lcrs_pkg::RISE_RD_MASK) == 8'h00)
    else $error("unused register bits set");

endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the current ramp sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] exp; int sel; string name;} lcrs_note_t;
  logic       i_ref_clk = 1'b0;
  logic       i_srst, i_osc_internal, i_reg_wr, i_shutdown_req, i_rise_enable, tick_on;
  logic       i_pwm_tick = 1'b0;
  logic [6:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, meas;
  logic [2:0] i_global_iset, o_master_dac;
  logic       o_in_hold, o_in_fade, o_in_rise, o_shutdown, o_osc_run;
  logic [31:0] seed = 32'h9787;
  int         bad_count = 0;
  int         cmp_count = 0;
  lcrs_note_t notes[$];
  lcrs_note_t note;
  lcrs_sequencer dut (.i_ref_clk, .i_srst, .i_pwm_tick, .i_osc_internal, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .i_shutdown_req, .i_rise_enable, .i_global_iset, .o_in_hold, .o_in_fade, .o_in_rise,
    .o_shutdown, .o_osc_run, .o_master_dac);
  always #50 i_ref_clk = ~i_ref_clk;
  // The timing tick pulses every other cycle to keep the long counts short.
  always @(negedge i_ref_clk) i_pwm_tick <= tick_on & ~i_pwm_tick;
  function automatic logic [7:0] seen(input int sel);
    case (sel)
      0: return o_reg_rdata;
      1: return {5'h00, o_master_dac};
      2: return {3'h0, o_osc_run, o_in_hold, o_in_fade, o_in_rise, o_shutdown};
      default: return meas;
    endcase
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Outputs are compared after the clock edge has settled them.
  always @(posedge i_ref_clk)
  begin
    #20;
    while (notes.size() > 0)
    begin
      note = notes.pop_front();
      check(note.name, seen(note.sel), note.exp);
    end
  end
  task automatic expect_out(input string name, input int sel, input logic [7:0] exp);
    notes.push_back(lcrs_note_t'{exp, sel, name});
    @(negedge i_ref_clk);
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_ref_clk);
    i_reg_wr = 1'b0;
    @(negedge i_ref_clk);
  endtask
  task automatic reg_rd(input logic [6:0] a, input logic [7:0] exp);
    i_reg_addr = a;
    @(negedge i_ref_clk);
    expect_out("rdata", 0, exp);
  endtask
  // Follows one sequence phase, checking the DAC direction, the cap and the oscillator hold.
  task automatic phase(input int which, input logic [2:0] cap, input int dir);
    logic [2:0] prev;
    logic       bad;
    int         n;
    int         ticks;
    ticks = 0;
    bad = 1'b0;
    prev = o_master_dac;
    for (n = 0; n < 20000 && (which == 0 ? o_in_hold : which == 1 ? o_in_fade : o_in_rise) === 1'b1; n++)
    begin
      if (i_pwm_tick === 1'b1)
        ticks++;
      if (o_master_dac > cap || (dir < 0 && o_master_dac > prev) || (dir > 0 && o_master_dac < prev)
          || (dir == 0 && o_master_dac !== cap) || o_osc_run !== 1'b1)
        bad = 1'b1;
      prev = o_master_dac;
      @(negedge i_ref_clk);
    end
    if (n >= 20000)
    begin
      $display("ERROR phase_end %0d expected done seen timeout", which);
      bad_count++;
    end
    meas = {7'h00, bad};
    expect_out("phase_shape", 3, 8'h00);
    meas = {7'h00, ticks >= 2040 && ticks <= 2050};
    expect_out("phase_ticks", 3, 8'h01);
  endtask
  initial
  begin
    {i_srst, i_osc_internal, i_global_iset} = 5'h1F;
    {i_reg_wr, i_shutdown_req, i_rise_enable, tick_on, i_reg_addr, i_reg_wdata} = 19'h0_0000;
    repeat (20) @(negedge i_ref_clk);
    i_srst = 1'b0;
    reg_rd(lcrs_pkg::ADDR_FADE_TIMING, lcrs_pkg::REG_RESET);
    reg_rd(lcrs_pkg::ADDR_RISE_TIMING, lcrs_pkg::REG_RESET);
    reg_rd(7'h20, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr_next(seed);
      reg_wr(lcrs_pkg::ADDR_FADE_TIMING, seed[7:0]);
      reg_wr(lcrs_pkg::ADDR_RISE_TIMING, seed[15:8]);
      reg_rd(lcrs_pkg::ADDR_FADE_TIMING, seed[7:0] & 8'h3F);
      reg_rd(lcrs_pkg::ADDR_RISE_TIMING, seed[15:8] & 8'h07);
    end
    $display("test registers done");
    reg_wr(lcrs_pkg::ADDR_FADE_TIMING, 8'h08);
    reg_wr(lcrs_pkg::ADDR_RISE_TIMING, 8'h01);
    {i_rise_enable, tick_on, i_shutdown_req} = 3'h7;
    expect_out("status", 2, 8'h18);
    phase(0, 3'h7, 0);
    expect_out("status", 2, 8'h01);
    i_shutdown_req = 1'b0;
    expect_out("status", 2, 8'h12);
    phase(2, 3'h7, 1);
    expect_out("dac", 1, 8'h07);
    $display("test hold and rise done");
    i_global_iset = 3'h3;
    reg_wr(lcrs_pkg::ADDR_FADE_TIMING, 8'h01);
    expect_out("dac", 1, 8'h03);
    i_shutdown_req = 1'b1;
    expect_out("status", 2, 8'h14);
    phase(1, 3'h3, -1);
    expect_out("status", 2, 8'h01);
    expect_out("dac", 1, 8'h00);
    reg_wr(lcrs_pkg::ADDR_RISE_TIMING, 8'h00);
    seed = lfsr_next(seed);
    i_global_iset = seed[2:0];
    i_shutdown_req = 1'b0;
    expect_out("status", 2, 8'h00);
    expect_out("dac", 1, {5'h00, seed[2:0]});
    $display("test fade and instant wake done");
    close_out();
  end
endmodule
`default_nettype wire
